// ===== xmo_pkg.sv
// Package for the extended data-memory operation unit: widths, constants,
// the operation enumeration and the structs that carry requests and results.
// Assumes a single core clock and a data memory with one cycle read latency.
package xmo_pkg;

	// Data and address widths of the core.
	localparam int XMO_DW = 8;
	localparam int XMO_AW = 16;

	// Bit positions used by the rotations.
	localparam int XMO_MSB = 7;
	localparam int XMO_LSB = 0;

	// Constants used by the arithmetic and the reset values.
	localparam logic [XMO_DW-1:0] XMO_ONE      = 8'h01;
	localparam logic [XMO_DW-1:0] XMO_ZERO     = 8'h00;
	localparam logic [XMO_DW-1:0] XMO_ACC_RST  = 8'h00;
	localparam logic [XMO_AW-1:0] XMO_ADDR_RST = 16'h0000;
	localparam logic              XMO_ZF_RST   = 1'b0;
	localparam logic              XMO_CF_RST   = 1'b0;

	// Operations that the decoder may hand to this unit.
	typedef enum logic [3:0] {
		OP_MEM_DEC_IN_PLACE,
		OP_MEM_DEC_TO_WORKING,
		OP_MEM_INC_IN_PLACE,
		OP_MEM_INC_TO_WORKING,
		OP_LOAD_WORKING_FROM_MEM,
		OP_STORE_WORKING_TO_MEM,
		OP_MEM_OR_TO_WORKING,
		OP_WORKING_OR_INTO_MEM,
		OP_MEM_ROL_IN_PLACE,
		OP_MEM_ROL_TO_WORKING,
		OP_MEM_ROL_VIA_CARRY,
		OP_MEM_ROL_VIA_CARRY_TO_WORKING
	} xmo_op_t;

	// Request from the decoder: the operation and the data-memory address.
	typedef struct packed {
		xmo_op_t           op;
		logic [XMO_AW-1:0] addr;
	} xmo_req_t;

	// Result of one operation and where it must go.
	typedef struct packed {
		logic [XMO_DW-1:0] value;
		logic              wr_mem;
		logic              wr_working;
		logic              upd_zero;
		logic              upd_carry;
		logic              carry;
	} xmo_res_t;

	// Phases of one operation.
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_READ,
		PH_EXEC
	} xmo_phase_t;

endpackage

// ===== xmo_alu.sv
// Combinational operation unit: computes the result of one operation from
// the memory operand, the working register and the carry flag.
// Assumes the caller applies the destination and flag enables it returns.
`timescale 1ns/10ps
`default_nettype none

module xmo_alu
	import xmo_pkg::*;
(
	input  wire xmo_op_t           op,      // Operation to perform.
	input  wire logic [XMO_DW-1:0] opnd,    // Byte read from data memory.
	input  wire logic [XMO_DW-1:0] working, // Current working register.
	input  wire logic              cin,     // Current carry flag.
	output xmo_res_t               res      // Result and its destinations.
);

	// Select the result, its destination and the flags it touches.
	always_comb begin
		res = '0;
		case (op)
			OP_MEM_DEC_IN_PLACE, OP_MEM_DEC_TO_WORKING: begin
				res.value    = opnd - XMO_ONE;
				res.upd_zero = 1'b1;
			end
			OP_MEM_INC_IN_PLACE, OP_MEM_INC_TO_WORKING: begin
				res.value    = opnd + XMO_ONE;
				res.upd_zero = 1'b1;
			end
			OP_LOAD_WORKING_FROM_MEM: begin
				res.value = opnd;
			end
			OP_STORE_WORKING_TO_MEM: begin
				res.value = working;
			end
			OP_MEM_OR_TO_WORKING, OP_WORKING_OR_INTO_MEM: begin
				res.value    = working | opnd;
				res.upd_zero = 1'b1;
			end
			OP_MEM_ROL_IN_PLACE, OP_MEM_ROL_TO_WORKING: begin
				res.value = {opnd[XMO_MSB-1:XMO_LSB], opnd[XMO_MSB]};
			end
			OP_MEM_ROL_VIA_CARRY, OP_MEM_ROL_VIA_CARRY_TO_WORKING: begin
				res.value     = {opnd[XMO_MSB-1:XMO_LSB], cin};
				res.upd_carry = 1'b1;
				res.carry     = opnd[XMO_MSB];
			end
			default: begin
				res.value = opnd;
			end
		endcase
		// Destination of the result: memory or the working register.
		case (op)
			OP_MEM_DEC_IN_PLACE, OP_MEM_INC_IN_PLACE,
			OP_STORE_WORKING_TO_MEM, OP_WORKING_OR_INTO_MEM,
			OP_MEM_ROL_IN_PLACE, OP_MEM_ROL_VIA_CARRY: begin
				res.wr_mem = 1'b1;
			end
			default: begin
				res.wr_working = 1'b1;
			end
		endcase
	end

endmodule

`default_nettype wire

// ===== xmo_core.sv
// Execution unit for extended-addressing data-memory operations: reads the
// addressed byte, applies the operation, writes memory or the working
// register and updates the zero and carry flags.
// Assumes a data memory on the same clock whose read data is valid in the
// cycle after the read strobe, and a decoder that waits for op_ready.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Decrement in place: memory byte minus one written back, zero flag only.
// - Decrement to working: byte minus one into working, memory kept, zero only.
// - Increment in place: memory byte plus one written back, zero flag only.
// - Increment to working: byte plus one into working, memory kept, zero only.
// - Load working: copy memory byte into working, no flag changes.
// - Store working: write working into memory, no flag changes.
// - OR to working: working OR byte into working, zero flag updated.
// - OR into memory: working OR byte written to memory, zero updated.
// - Rotate left in place: bit 7 to bit 0, written back, flags kept.
// - Rotate left to working: rotated byte into working, memory and flags kept.
// - Rotate via carry in place: old carry to bit 0, bit 7 to carry.
// - Rotate via carry to working: same rotation, result into working.
module xmo_core
	import xmo_pkg::*;
(
	input  wire logic              clk,          // Core clock, 10 MHz.
	input  wire logic              srst,         // Synchronous reset.
	input  wire logic              ce,           // Clock enable, freezes all.
	input  wire logic              op_valid,     // Decoder offers a request.
	input  wire xmo_req_t          op_req,       // Operation and address.
	output logic                   op_ready,     // Unit can take a request.
	output logic                   op_done,      // Operation completed pulse.
	output logic                   mem_rd_en,    // Data-memory read strobe.
	output logic                   mem_wr_en,    // Data-memory write strobe.
	output logic [XMO_AW-1:0]      mem_addr,     // Data-memory address.
	output logic [XMO_DW-1:0]      mem_wdata,    // Data-memory write data.
	input  wire logic [XMO_DW-1:0] mem_rdata,    // Data-memory read data.
	output logic [XMO_DW-1:0]      working_reg,  // Working register value.
	output logic                   zero_flag,    // Zero status flag.
	output logic                   carry_flag    // Carry status flag.
);

	// Complete state of the unit.
	typedef struct packed {
		xmo_phase_t        phase;
		xmo_req_t          req;
		logic              wr_en;
		logic [XMO_DW-1:0] wdata;
		logic [XMO_DW-1:0] working;
		logic              zf;
		logic              cf;
		logic              done;
	} xmo_state_t;

	xmo_state_t st_r;
	xmo_state_t st_nxt;
	xmo_res_t   res;

	// Operation unit fed by the memory operand, the working register and the carry flag.
	xmo_alu u_alu (
		.op      (st_r.req.op),
		.opnd    (mem_rdata),
		.working (st_r.working),
		.cin     (st_r.cf),
		.res     (res)
	);

	// Handshake strobes decoded from the phase.
	assign op_ready  = (st_r.phase == PH_IDLE);
	assign mem_rd_en = (st_r.phase == PH_READ);

	// Data outputs straight from the state flops.
	assign op_done     = st_r.done;
	assign mem_wr_en   = st_r.wr_en;
	assign mem_addr    = st_r.req.addr;
	assign mem_wdata   = st_r.wdata;
	assign working_reg = st_r.working;
	assign zero_flag   = st_r.zf;
	assign carry_flag  = st_r.cf;

	// Next-state logic: accept, read, then execute and commit.
	always_comb begin
		st_nxt       = st_r;
		st_nxt.wr_en = 1'b0;
		st_nxt.done  = 1'b0;
		case (st_r.phase)
			PH_IDLE: begin
				if (op_valid) begin
					st_nxt.req   = op_req;
					st_nxt.phase = PH_READ;
				end
			end
			PH_READ: begin
				st_nxt.phase = PH_EXEC;
			end
			PH_EXEC: begin
				st_nxt.phase = PH_IDLE;
				st_nxt.done  = 1'b1;
				if (res.wr_mem) begin
					st_nxt.wr_en = 1'b1;
					st_nxt.wdata = res.value;
				end
				if (res.wr_working) begin
					st_nxt.working = res.value;
				end
				if (res.upd_zero) begin
					st_nxt.zf = (res.value == XMO_ZERO);
				end
				if (res.upd_carry) begin
					st_nxt.cf = res.carry;
				end
			end
			default: begin
				st_nxt.phase = PH_IDLE;
			end
		endcase
	end

	// State register with synchronous reset and clock enable.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r.phase <= PH_IDLE;
			st_r.req   <= '{op: OP_LOAD_WORKING_FROM_MEM, addr: XMO_ADDR_RST};
			st_r.wr_en <= 1'b0;
			st_r.wdata <= XMO_ACC_RST;
			st_r.working <= XMO_ACC_RST;
			st_r.zf    <= XMO_ZF_RST;
			st_r.cf    <= XMO_CF_RST;
			st_r.done  <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Helper terms for the checks below.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	logic    fire;
	xmo_op_t cur_op;
	assign fire   = ce && (st_r.phase == PH_EXEC);
	assign cur_op = st_r.req.op;

	// A taken request reads memory next cycle, then finishes two later.
	op_latency_a: assert property (
		(op_valid && op_ready && ce) ##1 ce [*2]
		|-> !op_ready ##1 (op_done && op_ready))
		else $error("operation latency wrong");

	// Decrement in place writes byte minus one, zero flag only.
	dec_in_place_a: assert property (
		fire && cur_op == OP_MEM_DEC_IN_PLACE |=> mem_wr_en
		&& mem_wdata == $past(mem_rdata) - XMO_ONE
		&& zero_flag == (mem_wdata == XMO_ZERO) && $stable(carry_flag)
		&& $stable(working_reg))
		else $error("decrement in place wrong");

	// Decrement to working leaves memory alone.
	dec_to_working_a: assert property (
		fire && cur_op == OP_MEM_DEC_TO_WORKING |=> !mem_wr_en
		&& working_reg == $past(mem_rdata) - XMO_ONE
		&& zero_flag == (working_reg == XMO_ZERO) && $stable(carry_flag))
		else $error("decrement to working wrong");

	// Increment in place writes byte plus one.
	inc_in_place_a: assert property (
		fire && cur_op == OP_MEM_INC_IN_PLACE |=> mem_wr_en
		&& mem_wdata == $past(mem_rdata) + XMO_ONE
		&& zero_flag == (mem_wdata == XMO_ZERO) && $stable(carry_flag))
		else $error("increment in place wrong");

	// Increment to working leaves memory alone.
	inc_to_working_a: assert property (
		fire && cur_op == OP_MEM_INC_TO_WORKING |=> !mem_wr_en
		&& working_reg == $past(mem_rdata) + XMO_ONE && $stable(carry_flag))
		else $error("increment to working wrong");

	// Increment of the top value wraps to zero and sets the zero flag.
	inc_wrap_a: assert property (
		fire && cur_op == OP_MEM_INC_IN_PLACE && mem_rdata == 8'hff
		|=> mem_wdata == XMO_ZERO && zero_flag)
		else $error("increment wrap wrong");

	// Load copies the byte and keeps both flags.
	load_working_a: assert property (
		fire && cur_op == OP_LOAD_WORKING_FROM_MEM |=> !mem_wr_en
		&& working_reg == $past(mem_rdata) && $stable(zero_flag)
		&& $stable(carry_flag))
		else $error("load working wrong");

	// Store writes the working register and keeps both flags.
	store_working_a: assert property (
		fire && cur_op == OP_STORE_WORKING_TO_MEM |=> mem_wr_en
		&& mem_wdata == $past(working_reg) && $stable(zero_flag)
		&& $stable(carry_flag))
		else $error("store working wrong");

	// OR into working updates the zero flag.
	or_to_working_a: assert property (
		fire && cur_op == OP_MEM_OR_TO_WORKING |=> !mem_wr_en
		&& working_reg == ($past(working_reg) | $past(mem_rdata))
		&& zero_flag == (working_reg == XMO_ZERO))
		else $error("or to working wrong");

	// OR into memory keeps the working register.
	or_into_mem_a: assert property (
		fire && cur_op == OP_WORKING_OR_INTO_MEM |=> mem_wr_en
		&& mem_wdata == ($past(working_reg) | $past(mem_rdata))
		&& zero_flag == (mem_wdata == XMO_ZERO) && $stable(working_reg))
		else $error("or into memory wrong");

	// Plain rotate in place moves bit 7 to bit 0 and keeps flags.
	rol_in_place_a: assert property (
		fire && cur_op == OP_MEM_ROL_IN_PLACE |=> mem_wr_en
		&& mem_wdata == {$past(mem_rdata[XMO_MSB-1:XMO_LSB]),
			$past(mem_rdata[XMO_MSB])}
		&& $stable(zero_flag) && $stable(carry_flag))
		else $error("rotate in place wrong");

	// Plain rotate to working keeps memory and flags.
	rol_to_working_a: assert property (
		fire && cur_op == OP_MEM_ROL_TO_WORKING |=> !mem_wr_en
		&& working_reg == {$past(mem_rdata[XMO_MSB-1:XMO_LSB]),
			$past(mem_rdata[XMO_MSB])}
		&& $stable(zero_flag) && $stable(carry_flag))
		else $error("rotate to working wrong");

	// Rotate through carry in place moves old carry to bit 0 and bit 7 to carry.
	rlc_in_place_a: assert property (
		fire && cur_op == OP_MEM_ROL_VIA_CARRY |=> mem_wr_en
		&& mem_wdata == {$past(mem_rdata[XMO_MSB-1:XMO_LSB]),
			$past(carry_flag)}
		&& carry_flag == $past(mem_rdata[XMO_MSB]) && $stable(zero_flag))
		else $error("rotate via carry wrong");

	// Rotate through carry to working keeps memory.
	rlc_to_working_a: assert property (
		fire && cur_op == OP_MEM_ROL_VIA_CARRY_TO_WORKING |=> !mem_wr_en
		&& working_reg == {$past(mem_rdata[XMO_MSB-1:XMO_LSB]),
			$past(carry_flag)}
		&& carry_flag == $past(mem_rdata[XMO_MSB]))
		else $error("rotate via carry to working wrong");

	// A taken request raises the read strobe with its address next cycle.
	read_strobe_a: assert property (
		(op_valid && op_ready && ce)
		|=> mem_rd_en && !op_ready && mem_addr == $past(op_req.addr))
		else $error("read strobe wrong");

	// Done and write strobes last exactly one enabled cycle.
	strobe_pulse_a: assert property (
		ce && (op_done || mem_wr_en) |=> !op_done && !mem_wr_en)
		else $error("strobe pulse too long");

	// A memory write only comes with the completion pulse.
	write_with_done_a: assert property (
		mem_wr_en |-> op_done)
		else $error("write without completion");

	// Completion is signalled while the unit is already idle again.
	done_ready_a: assert property (
		op_done |-> op_ready)
		else $error("done while busy");

	// Write data changes only when a write is issued.
	wdata_hold_a: assert property (
		$changed(mem_wdata) |-> mem_wr_en)
		else $error("write data moved without write");

	// The address holds while an operation is in flight.
	addr_hold_a: assert property (
		!op_ready |=> $stable(mem_addr))
		else $error("address moved while busy");

	// With no request taken the unit stays idle.
	idle_hold_a: assert property (
		op_ready && !(op_valid && ce) |=> op_ready)
		else $error("left idle without request");

	// Working register and flags change only as an operation completes.
	state_on_done_a: assert property (
		$changed(working_reg) || $changed(zero_flag)
		|| $changed(carry_flag) |-> op_done)
		else $error("state changed outside completion");

	// Low clock enable freezes the flags, working register, address, ready, done and write strobe.
	ce_freeze_a: assert property (
		!ce |=> $stable(working_reg) && $stable(zero_flag)
		&& $stable(carry_flag) && $stable(mem_addr)
		&& $stable(op_ready) && $stable(op_done) && $stable(mem_wr_en))
		else $error("clock enable does not freeze");

	// Reset forces the idle state and the chosen reset values.
	reset_values_a: assert property (disable iff (1'b0)
		srst |=> op_ready && !op_done && !mem_rd_en && !mem_wr_en
		&& working_reg == XMO_ACC_RST && mem_addr == XMO_ADDR_RST
		&& zero_flag == XMO_ZF_RST && carry_flag == XMO_CF_RST)
		else $error("reset values wrong");

endmodule

`default_nettype wire

// ===== tb_extended_mem_operand_alu_ops.sv
// Self-checking bench for the extended data-memory operation unit.
// Assumes the unit's package is compiled first; the bench acts as decoder
// and as a data memory with one cycle read latency.
`timescale 1ns/10ps
`default_nettype none

module tb_extended_mem_operand_alu_ops;
	import xmo_pkg::*;

	logic              clk;
	logic              srst;
	logic              ce;
	logic              op_valid;
	xmo_req_t          op_req;
	logic              op_ready;
	logic              op_done;
	logic              mem_rd_en;
	logic              mem_wr_en;
	logic [XMO_AW-1:0] mem_addr;
	logic [XMO_DW-1:0] mem_wdata;
	logic [XMO_DW-1:0] mem_rdata;
	logic [XMO_DW-1:0] working_reg;
	logic              zero_flag;
	logic              carry_flag;
	logic [XMO_DW-1:0] mem [0:15];
	logic              rd_q;
	logic [XMO_DW-1:0] m_acc;
	logic              m_z;
	logic              m_c;
	int                error_cnt;
	int                cmp_count;

	xmo_core uut (
		.clk         (clk),
		.srst        (srst),
		.ce          (ce),
		.op_valid    (op_valid),
		.op_req      (op_req),
		.op_ready    (op_ready),
		.op_done     (op_done),
		.mem_rd_en   (mem_rd_en),
		.mem_wr_en   (mem_wr_en),
		.mem_addr    (mem_addr),
		.mem_wdata   (mem_wdata),
		.mem_rdata   (mem_rdata),
		.working_reg (working_reg),
		.zero_flag   (zero_flag),
		.carry_flag  (carry_flag)
	);

	// The clock toggles every half period of 50 ns.
	always #50 clk = ~clk;

	// Memory takes writes and read strobes on the rising edge.
	always @(posedge clk) begin
		if (mem_wr_en && ce) begin
			mem[mem_addr[3:0]] <= mem_wdata;
		end
		rd_q <= mem_rd_en && ce;
	end

	// Read data appears in the next cycle; otherwise the bus toggles.
	always @(negedge clk) begin
		mem_rdata <= rd_q ? mem[mem_addr[3:0]] : ~mem_rdata;
	end

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [7:0] e,
			input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("Compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Runs one operation, predicts its effect and checks every port.
	task automatic exec(input xmo_op_t op, input logic [3:0] k,
			input int s = 0);
		logic [7:0]  m;
		logic [7:0]  r;
		logic        wm;
		logic        wa;
		logic        uz;
		logic        uc;
		logic [15:0] a;
		int          n;
		a = {12'h0A0, k};
		m = mem[k];
		r = m;
		wm = 1'b0;
		wa = 1'b0;
		uz = 1'b0;
		uc = 1'b0;
		case (op)
			OP_MEM_DEC_IN_PLACE: begin r = m - 8'h01; wm = 1; uz = 1; end
			OP_MEM_DEC_TO_WORKING: begin r = m - 8'h01; wa = 1; uz = 1; end
			OP_MEM_INC_IN_PLACE: begin r = m + 8'h01; wm = 1; uz = 1; end
			OP_MEM_INC_TO_WORKING: begin r = m + 8'h01; wa = 1; uz = 1; end
			OP_LOAD_WORKING_FROM_MEM: begin wa = 1; end
			OP_STORE_WORKING_TO_MEM: begin r = m_acc; wm = 1; end
			OP_MEM_OR_TO_WORKING: begin r = m | m_acc; wa = 1; uz = 1; end
			OP_WORKING_OR_INTO_MEM: begin r = m | m_acc; wm = 1; uz = 1; end
			OP_MEM_ROL_IN_PLACE: begin r = {m[6:0], m[7]}; wm = 1; end
			OP_MEM_ROL_TO_WORKING: begin r = {m[6:0], m[7]}; wa = 1; end
			OP_MEM_ROL_VIA_CARRY: begin r = {m[6:0], m_c}; wm = 1; uc = 1; end
			default: begin r = {m[6:0], m_c}; wa = 1; uc = 1; end
		endcase
		@(negedge clk);
		op_valid = 1'b1;
		op_req = '{op: op, addr: a};
		@(negedge clk);
		op_valid = 1'b0;
		chk("op_ready", 8'h00, {7'h00, op_ready});
		chk("mem_rd_en", 8'h01, {7'h00, mem_rd_en});
		if (mem_addr !== a) begin
			error_cnt++;
			$display("ERROR mem_addr expected %h seen %h", a, mem_addr);
		end
		// Optional stall: clock enable low keeps the unit in its read phase.
		if (s > 0) begin
			ce = 1'b0;
			repeat (s) @(negedge clk);
			chk("stall_rd_en", 8'h01, {7'h00, mem_rd_en});
			ce = 1'b1;
		end
		n = 1 + s;
		while (op_done !== 1'b1 && n < 8 + s) begin
			@(negedge clk);
			n++;
		end
		m_acc = wa ? r : m_acc;
		m_z = uz ? (r == 8'h00) : m_z;
		m_c = uc ? m[7] : m_c;
		chk("done_cycle", 8'h03 + 8'(s), 8'(n));
		chk("mem_wr_en", {7'h00, wm}, {7'h00, mem_wr_en});
		if (wm) begin
			chk("mem_wdata", r, mem_wdata);
		end
		chk("working_reg", m_acc, working_reg);
		chk("zero_flag", {7'h00, m_z}, {7'h00, zero_flag});
		chk("carry_flag", {7'h00, m_c}, {7'h00, carry_flag});
		@(posedge clk);
		#1;
		chk("mem_byte", wm ? r : m, mem[k]);
	endtask

	// Increments and decrements wrap and touch only the zero flag.
	task automatic t_incdec;
		mem[3] = 8'h80;
		mem[1] = 8'hFF;
		mem[2] = 8'h00;
		exec(OP_MEM_ROL_VIA_CARRY, 4'h3);
		exec(OP_MEM_INC_IN_PLACE, 4'h1);
		exec(OP_MEM_DEC_TO_WORKING, 4'h1);
		exec(OP_MEM_DEC_IN_PLACE, 4'h2);
		exec(OP_MEM_INC_TO_WORKING, 4'h2);
		exec(OP_MEM_DEC_IN_PLACE, 4'h2);
		$display("Test incdec done");
	endtask

	// Moves keep both flags while data goes each way.
	task automatic t_moves;
		mem[4] = 8'h5A;
		mem[5] = 8'h33;
		exec(OP_LOAD_WORKING_FROM_MEM, 4'h4, 2);
		exec(OP_STORE_WORKING_TO_MEM, 4'h5);
		$display("Test moves done");
	endtask

	// OR to either destination, with zero set and cleared.
	task automatic t_or;
		mem[6] = 8'hA5;
		mem[7] = 8'h00;
		exec(OP_MEM_OR_TO_WORKING, 4'h6);
		exec(OP_LOAD_WORKING_FROM_MEM, 4'h7);
		exec(OP_WORKING_OR_INTO_MEM, 4'h7);
		exec(OP_WORKING_OR_INTO_MEM, 4'h6);
		exec(OP_MEM_OR_TO_WORKING, 4'h7);
		$display("Test or done");
	endtask

	// Plain and through-carry rotations, carry in both states.
	task automatic t_rotate;
		mem[8] = 8'h81;
		mem[9] = 8'h40;
		mem[10] = 8'h80;
		mem[11] = 8'h01;
		mem[12] = 8'h7F;
		exec(OP_MEM_ROL_IN_PLACE, 4'h8);
		exec(OP_MEM_ROL_TO_WORKING, 4'h9);
		exec(OP_MEM_ROL_VIA_CARRY, 4'hA);
		exec(OP_MEM_ROL_VIA_CARRY_TO_WORKING, 4'hB);
		exec(OP_MEM_ROL_VIA_CARRY, 4'hC, 1);
		exec(OP_MEM_ROL_VIA_CARRY_TO_WORKING, 4'hA);
		exec(OP_MEM_ROL_TO_WORKING, 4'h8);
		$display("Test rotate done");
	endtask

	// Cuts a hang short well beyond the expected run time.
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end

	// Resets the unit, checks reset values, then runs every scenario.
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		ce = 1'b1;
		op_valid = 1'b0;
		op_req = '{op: OP_MEM_DEC_IN_PLACE, addr: XMO_ADDR_RST};
		mem_rdata = 8'h00;
		rd_q = 1'b0;
		m_acc = 8'h00;
		m_z = 1'b0;
		m_c = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		chk("ready_rst", 8'h01, {7'h00, op_ready});
		chk("acc_rst", 8'h00, working_reg);
		chk("flags_rst", 8'h00, {6'h00, zero_flag, carry_flag});
		chk("strobes_rst", 8'h00, {5'h00, op_done, mem_rd_en, mem_wr_en});
		chk("addr_rst", 8'h00, mem_addr[15:8] | mem_addr[7:0]);
		chk("wdata_rst", 8'h00, mem_wdata);
		t_incdec();
		t_moves();
		t_or();
		t_rotate();
		wrap_up();
	end

endmodule

`default_nettype wire
